// File: core/quad_pkg.sv
// Package: register map, field layout and state of the quadrature status block
package quad_pkg;

    localparam int ADDR_W = 18;

    // Register indexes; byte address is four times the index
    localparam logic [15:0] STAT_IDX = 16'ha071;
    localparam logic [15:0] COUNT_IDX = 16'ha074;
    localparam logic [15:0] LIMIT_IDX = 16'ha076;
    localparam logic [15:0] ISTAT_IDX = 16'ha078;
    localparam logic [15:0] IMASK_IDX = 16'ha079;

    localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] COUNT_ADDR = {COUNT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] LIMIT_ADDR = {LIMIT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] ISTAT_ADDR = {ISTAT_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] IMASK_ADDR = {IMASK_IDX, 2'b00};

    // Bit positions in the status/reload register
    localparam int B_DIR = 7;
    localparam int B_FAULT = 6;
    localparam int B_RSEL = 4;
    localparam int B_TC = 3;
    localparam int B_IDX = 2;
    localparam int B_REV = 1;
    localparam int B_CNT = 0;

    // Event bit positions in interrupt status and mask
    localparam int E_CNT = 0;
    localparam int E_REV = 1;
    localparam int E_IDX = 2;
    localparam int E_TC = 3;
    localparam int E_FAULT = 4;
    localparam int EV_W = 5;

    // Reload select encodings
    localparam logic [1:0] RSEL_NONE = 2'h0;
    localparam logic [1:0] RSEL_INDEX = 2'h1;
    localparam logic [1:0] RSEL_TC = 2'h2;
    localparam logic [1:0] RSEL_BOTH = 2'h3;

    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [14:0] LIMIT_RESET = 15'h0000;

    typedef struct packed {
        logic quad_input_a;
        logic quad_input_b;
        logic index;
    } quad_in_t;

    typedef struct packed {
        logic primed;
        logic [1:0] ab_prev;
        logic idx_prev;
        logic dir_up;
        logic phase_fault_flag;
        logic [1:0] reload_select;
        logic terminal_count_flag;
        logic index_event_flag;
        logic reversal_event_flag;
        logic count_change_flag;
        logic [15:0] position_count;
        logic [14:0] position_limit;
        logic [EV_W-1:0] int_stat;
        logic [EV_W-1:0] int_mask;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } state_t;

    localparam state_t STATE_RESET = '0;

endpackage

// File: core/quad_decoder_status_reload.sv
// Quadrature decoder status flags, reload control and APB register slave
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module quad_decoder_status_reload
    import quad_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire quad_in_t quad_in,
    output logic irq
);

    state_t st_reg;
    state_t st_next;

    logic [1:0] ab_cur;
    logic [1:0] ab_chg;
    logic step;
    logic both_chg;
    logic step_up;
    logic up_now;
    logic idx_ev;
    logic at_term;
    logic tc_ev;
    logic rev_ev;
    logic reload;
    logic [15:0] reload_val;
    logic [15:0] limit_ext;
    logic acc;
    logic done;
    logic wr;
    logic mapped;
    logic wr_stat;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic wr_lim_lo;
    logic wr_lim_hi;
    logic wr_istat;
    logic wr_imask;
    logic [7:0] stat_view;
    logic [31:0] rd_mux;
    logic [EV_W-1:0] ev_vec;

    assign ab_cur = {quad_in.quad_input_a, quad_in.quad_input_b};
    assign ab_chg = st_reg.primed ? (ab_cur ^ st_reg.ab_prev) : 2'b00;
    assign step = ab_chg[1] ^ ab_chg[0];
    assign both_chg = &ab_chg;
    // Forward sequence 00,10,11,01: new A differs from old B
    assign step_up = ab_cur[1] ^ st_reg.ab_prev[0];
    assign up_now = step ? step_up : st_reg.dir_up;
    assign idx_ev = st_reg.primed & quad_in.index & ~st_reg.idx_prev;
    assign limit_ext = {1'b0, st_reg.position_limit};
    assign at_term = up_now ? (st_reg.position_count == limit_ext)
                            : (st_reg.position_count == COUNT_RESET);
    assign tc_ev = step & at_term;
    assign rev_ev = step & (step_up != st_reg.dir_up);
    // reload source per select; neither bit set
    assign reload = (idx_ev & st_reg.reload_select[0])
                  | (tc_ev & st_reg.reload_select[1]);
    assign reload_val = up_now ? COUNT_RESET : limit_ext;
    assign ev_vec = {both_chg, tc_ev, idx_ev, rev_ev, step};

    assign acc = psel & penable;
    assign done = acc & st_reg.pready;
    assign wr = done & pwrite;
    assign mapped = (paddr == STAT_ADDR) | (paddr == COUNT_ADDR)
                  | (paddr == LIMIT_ADDR) | (paddr == ISTAT_ADDR)
                  | (paddr == IMASK_ADDR);
    assign wr_stat = wr & (paddr == STAT_ADDR) & pstrb[0];
    assign wr_cnt_lo = wr & (paddr == COUNT_ADDR) & pstrb[0];
    assign wr_cnt_hi = wr & (paddr == COUNT_ADDR) & pstrb[1];
    assign wr_lim_lo = wr & (paddr == LIMIT_ADDR) & pstrb[0];
    assign wr_lim_hi = wr & (paddr == LIMIT_ADDR) & pstrb[1];
    assign wr_istat = wr & (paddr == ISTAT_ADDR) & pstrb[0];
    assign wr_imask = wr & (paddr == IMASK_ADDR) & pstrb[0];

    assign stat_view = {st_reg.dir_up, st_reg.phase_fault_flag,
                        st_reg.reload_select, st_reg.terminal_count_flag,
                        st_reg.index_event_flag, st_reg.reversal_event_flag,
                        st_reg.count_change_flag};

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == STAT_ADDR) begin
            rd_mux = {24'h00_0000, stat_view};
        end else if (paddr == COUNT_ADDR) begin
            rd_mux = {16'h0000, st_reg.position_count};
        end else if (paddr == LIMIT_ADDR) begin
            rd_mux = {17'h0_0000, st_reg.position_limit};
        end else if (paddr == ISTAT_ADDR) begin
            rd_mux = {27'h000_0000, st_reg.int_stat};
        end else if (paddr == IMASK_ADDR) begin
            rd_mux = {27'h000_0000, st_reg.int_mask};
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.primed = 1'b1;
        st_next.ab_prev = ab_cur;
        st_next.idx_prev = quad_in.index;
        if (step) begin
            st_next.dir_up = step_up;
        end

        // set wins over a clearing write
        st_next.phase_fault_flag = (st_reg.phase_fault_flag
            & ~(wr_stat & ~pwdata[B_FAULT])) | both_chg;
        // write 0 clears, write 1 keeps, event wins
        st_next.terminal_count_flag = (st_reg.terminal_count_flag
            & ~(wr_stat & ~pwdata[B_TC])) | tc_ev;
        st_next.index_event_flag = (st_reg.index_event_flag
            & ~(wr_stat & ~pwdata[B_IDX])) | idx_ev;
        st_next.count_change_flag = (st_reg.count_change_flag
            & ~(wr_stat & ~pwdata[B_CNT])) | step;
        st_next.reversal_event_flag = (st_reg.reversal_event_flag
            & ~(wr_stat & ~pwdata[B_REV])) | rev_ev;
        if (wr_stat) begin
            st_next.reload_select = pwdata[B_RSEL+1:B_RSEL];
        end

        if (reload) begin
            st_next.position_count = reload_val;
        end else if (step) begin
            st_next.position_count = step_up
                ? st_reg.position_count + 16'h0001
                : st_reg.position_count - 16'h0001;
        end
        // Software load beats a same-cycle step
        if (wr_cnt_lo) begin
            st_next.position_count[7:0] = pwdata[7:0];
        end
        if (wr_cnt_hi) begin
            st_next.position_count[15:8] = pwdata[15:8];
        end
        if (wr_lim_lo) begin
            st_next.position_limit[7:0] = pwdata[7:0];
        end
        if (wr_lim_hi) begin
            st_next.position_limit[14:8] = pwdata[14:8];
        end

        // Interrupt status: write one to clear, set wins
        st_next.int_stat = (st_reg.int_stat
            & ~(wr_istat ? pwdata[EV_W-1:0] : '0)) | ev_vec;
        if (wr_imask) begin
            st_next.int_mask = pwdata[EV_W-1:0];
        end
        st_next.irq = |(st_next.int_stat & st_next.int_mask);

        // One wait state: answer on second access cycle
        st_next.pready = acc & ~st_reg.pready;
        st_next.pslverr = acc & ~st_reg.pready & ~mapped;
        st_next.prdata = (acc & ~st_reg.pready & ~pwrite & mapped)
                       ? rd_mux : 32'h0000_0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= STATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign irq = st_reg.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_reverse_step;
        step && (step_up != st_reg.dir_up) && !wr_stat;
    endsequence

    a_apb_answer: assert property (
        s_setup ##1 (psel && penable) |=> pready)
        else $error("APB answer not after one wait state");

    a_fault_set: assert property (
        both_chg |=> st_reg.phase_fault_flag && stat_view[B_FAULT])
        else $error("Phase fault flag not set on double change");

    a_wrap_free: assert property (
        st_reg.reload_select == RSEL_NONE && step && !wr
        && st_reg.position_count == 16'hffff && step_up
        |=> st_reg.position_count == 16'h0000)
        else $error("Free count did not wrap upward");

    a_index_reload: assert property (
        st_reg.reload_select == RSEL_INDEX && idx_ev && !wr
        |=> st_reg.position_count
            == ($past(up_now) ? 16'h0000 : $past(limit_ext)))
        else $error("Index reload value wrong");

    a_both_first: assert property (
        st_reg.reload_select == RSEL_BOTH && (idx_ev || tc_ev) && !wr
        |=> st_reg.position_count
            == ($past(up_now) ? 16'h0000 : $past(limit_ext)))
        else $error("Combined reload missed first event");

    a_reversal_seen: assert property (
        s_reverse_step |=> st_reg.reversal_event_flag
        && stat_view[B_DIR] == $past(step_up))
        else $error("Reversal not flagged or direction wrong");

    a_tc_reload: assert property (
        st_reg.reload_select == RSEL_TC && tc_ev && !wr && step_up
        |=> st_reg.position_count == 16'h0000)
        else $error("Terminal reload upward not zero");

    a_tc_flag: assert property (
        tc_ev |=> st_reg.terminal_count_flag ##1 st_reg.int_stat[E_TC]
        || $past(wr_istat))
        else $error("Terminal count flag not raised");

    a_flag_hold: assert property (
        st_reg.index_event_flag && !(wr_stat && !pwdata[B_IDX])
        |=> st_reg.index_event_flag [*1])
        else $error("Index flag lost without clearing write");

    a_irq_level: assert property (
        (st_reg.int_stat & st_reg.int_mask) != '0 |-> irq)
        else $error("Interrupt low with unmasked status set");

endmodule // quad_decoder_status_reload

// File: sim/quad_encoder_model.sv
// Behavioural quadrature encoder that drives the decoder's inputs
`timescale 1ns/1ps
module quad_encoder_model
    import quad_pkg::*;
(
    input logic pclk,
    output quad_in_t quad_in
);
    logic [1:0] ph = 2'h0;
    initial quad_in = '0;
    // Gray order 00,10,11,01 is counting up
    function automatic logic [1:0] gray(input logic [1:0] p);
        return {p[1] ^ p[0], p[1]};
    endfunction
    task automatic settle();
        repeat (2) @(posedge pclk);
    endtask
    task automatic step(input logic up);
        ph = up ? ph + 2'h1 : ph - 2'h1;
        @(posedge pclk);
        quad_in <= {gray(ph), quad_in.index};
        settle();
    endtask
    task automatic fault();
        ph = ph + 2'h2;
        @(posedge pclk);
        quad_in <= {gray(ph), quad_in.index};
        settle();
    endtask
    task automatic index();
        @(posedge pclk);
        quad_in.index <= 1'b1;
        @(posedge pclk);
        quad_in.index <= 1'b0;
        settle();
    endtask
endmodule // quad_encoder_model

// File: sim/tb.sv
// Self-checking bench for the quadrature status and reload block
`timescale 1ns/1ps
module tb;
    import quad_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, irq, err;
    quad_in_t quad_in;
    int fails = 0;
    int checks = 0;
    always #25 pclk = ~pclk;
    quad_decoder_status_reload DUT (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .quad_in(quad_in), .irq(irq));
    quad_encoder_model enc (.pclk(pclk), .quad_in(quad_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never completes
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                         input logic [31:0] m = 32'hffffffff);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic irqchk(input logic e);
        @(posedge pclk);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task automatic t_reset();
        rdchk(STAT_ADDR, 32'h0);
        rdchk(COUNT_ADDR, 32'h0);
        // Unmapped word answers with an error
        apb(1'b0, 18'h00010, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_wrap();
        apb(1'b1, COUNT_ADDR, 32'hffff);
        enc.step(1'b1);
        rdchk(COUNT_ADDR, 32'h0);
        apb(1'b1, STAT_ADDR, 32'h0);
        enc.step(1'b0);
        rdchk(COUNT_ADDR, 32'hffff);
        rdchk(STAT_ADDR, 32'h0b);
        apb(1'b1, STAT_ADDR, 32'h02);
        rdchk(STAT_ADDR, 32'h02);
        apb(1'b1, STAT_ADDR, 32'h0);
        rdchk(STAT_ADDR, 32'h0);
        enc.fault();
        rdchk(STAT_ADDR, 32'h40);
        rdchk(COUNT_ADDR, 32'hffff);
        $display("test wrap and flags done");
    endtask
    task automatic t_index();
        apb(1'b1, STAT_ADDR, 32'h10);
        apb(1'b1, LIMIT_ADDR, 32'h5);
        apb(1'b1, COUNT_ADDR, 32'h3);
        enc.step(1'b1);
        enc.index();
        rdchk(COUNT_ADDR, 32'h0);
        rdchk(STAT_ADDR, 32'h04, 32'h04);
        enc.step(1'b0);
        rdchk(COUNT_ADDR, 32'hffff);
        enc.index();
        rdchk(COUNT_ADDR, 32'h5);
        $display("test index reload done");
    endtask
    task automatic t_tc();
        apb(1'b1, STAT_ADDR, 32'h20);
        apb(1'b1, COUNT_ADDR, 32'h4);
        enc.step(1'b1);
        rdchk(COUNT_ADDR, 32'h5);
        enc.step(1'b1);
        rdchk(COUNT_ADDR, 32'h0);
        rdchk(STAT_ADDR, 32'h08, 32'h08);
        enc.step(1'b0);
        rdchk(COUNT_ADDR, 32'h5);
        $display("test terminal reload done");
    endtask
    task automatic t_both();
        apb(1'b1, STAT_ADDR, 32'h30);
        apb(1'b1, COUNT_ADDR, 32'h4);
        enc.step(1'b1);
        enc.step(1'b1);
        rdchk(COUNT_ADDR, 32'h0);
        enc.step(1'b1);
        enc.index();
        rdchk(COUNT_ADDR, 32'h0);
        $display("test both reloads done");
    endtask
    task automatic t_irq();
        apb(1'b1, IMASK_ADDR, 32'h1 << E_CNT);
        apb(1'b1, ISTAT_ADDR, 32'h1f);
        irqchk(1'b0);
        enc.step(1'b1);
        irqchk(1'b1);
        rdchk(ISTAT_ADDR, 32'h1, 32'h1);
        apb(1'b1, ISTAT_ADDR, 32'h1);
        irqchk(1'b0);
        enc.step(1'b1);
        irqchk(1'b1);
        // Masking alone drops the line
        apb(1'b1, IMASK_ADDR, 32'h0);
        irqchk(1'b0);
        $display("test interrupt done");
    endtask
    task automatic t_lanes();
        apb(1'b1, COUNT_ADDR, 32'h1234);
        pstrb <= 4'h1;
        apb(1'b1, COUNT_ADDR, 32'hab56);
        rdchk(COUNT_ADDR, 32'h1256);
        pstrb <= 4'h2;
        apb(1'b1, LIMIT_ADDR, 32'h7f03);
        rdchk(LIMIT_ADDR, 32'h7f05);
        // No lane enabled: write refused
        pstrb <= 4'h0;
        apb(1'b1, STAT_ADDR, 32'h00);
        rdchk(STAT_ADDR, 32'h30, 32'h30);
        pstrb <= 4'hf;
        apb(1'b1, COUNT_ADDR, 32'h7f04);
        enc.step(1'b1);
        rdchk(COUNT_ADDR, 32'h7f05);
        enc.step(1'b1);
        rdchk(COUNT_ADDR, 32'h0);
        $display("test byte lanes done");
    endtask
    task automatic give_verdict();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_wrap();
        t_index();
        t_tc();
        t_both();
        t_irq();
        t_lanes();
        give_verdict();
    end
    initial begin
        #2000000;
        fails++;
        give_verdict();
    end
endmodule // tb
